// file: shared/scpm_pkg.sv
// Purpose: Shared constants and types for the socket clock power block
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Offsets are byte addresses
package scpm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  PM_OFS       = 8'h20;
  localparam logic [7:0]  IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0]  IRQ_MASK_OFS = 8'h28;
  localparam logic [7:0]  POLICY_OFS   = 8'h2C;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned SEL_BIT      = 0;
  localparam int unsigned EN_BIT       = 16;
  localparam int unsigned MODE_BIT     = 24;
  localparam int unsigned ACC_BIT      = 25;
  localparam int unsigned POLICY_BIT   = 0;
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_ACC_BIT  = 0;
  localparam int unsigned IRQ_MODE_BIT = 1;

  ////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic        BIT_RST      = 1'h0;
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic enable;
    logic select;
    logic policy;
  } scpm_ctrl_t;

  typedef struct packed {
    logic idle;
    logic host_prep;
  } scpm_sock_t;

  typedef enum logic [1:0] {
    SCPM_RUN  = 2'b00,
    SCPM_STOP = 2'b01,
    SCPM_SLOW = 2'b10
  } scpm_clk_st_t;

endpackage : scpm_pkg

// file: rtl/scpm_clk_policy.sv
// Purpose: Card clock stop or slow decision
// Assumes: Socket inputs already synchronised
// Notes:   Stop and slow outputs are registered; rate_changed is their OR
`timescale 1ns/100ps
module scpm_clk_policy
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Control and socket state
  input  wire scpm_pkg::scpm_ctrl_t ctrl,
  input  wire scpm_pkg::scpm_sock_t sock,
  // Clock requests
  output logic                    clk_stop,
  output logic                    clk_slow,
  output logic                    rate_changed
);

  scpm_pkg::scpm_clk_st_t st_ff;
  scpm_pkg::scpm_clk_st_t nxt_st;
  logic                   stop_ff;
  logic                   slow_ff;
  logic                   nxt_stop;
  logic                   nxt_slow;
  logic                   permit;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    permit = ctrl.enable & sock.idle & (ctrl.policy | sock.host_prep);
    nxt_st = st_ff;
    if (ce)
    begin
      unique case (st_ff)
        scpm_pkg::SCPM_RUN,
        scpm_pkg::SCPM_STOP,
        scpm_pkg::SCPM_SLOW:
        begin
          if (!permit)
            nxt_st = scpm_pkg::SCPM_RUN;
          else if (ctrl.select)
            nxt_st = scpm_pkg::SCPM_SLOW;
          else
            nxt_st = scpm_pkg::SCPM_STOP;
        end
        default:
          nxt_st = scpm_pkg::SCPM_RUN;
      endcase
    end
    nxt_stop = (nxt_st == scpm_pkg::SCPM_STOP);
    nxt_slow = (nxt_st == scpm_pkg::SCPM_SLOW);
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff   <= scpm_pkg::SCPM_RUN;
      stop_ff <= scpm_pkg::BIT_RST;
      slow_ff <= scpm_pkg::BIT_RST;
    end
    else
    begin
      st_ff   <= nxt_st;
      stop_ff <= nxt_stop;
      slow_ff <= nxt_slow;
    end
  end

  assign clk_stop     = stop_ff;
  assign clk_slow     = slow_ff;
  assign rate_changed = stop_ff | slow_ff;

endmodule : scpm_clk_policy

// file: rtl/scpm_top.sv
// Purpose: Socket power-management register with APB access
// Assumes: Socket pins are asynchronous to sys_clk
// Notes:   One wait state on every APB access
//
// Functional notes
// - Any card access while ce is high sets the access-seen flag at bit 25; zero after reset.
// - Reading the register clears the access-seen flag it returned.
// - Read-only bit 24 shows 1 while the card clock rate is changed.
// - Stop-or-slow select acts only while enable bit 16 is set; enable resets 0.
// - When enabled and idle, bit 0 low stops the clock, high requests the slow clock.
// - Bits 31 to 26 always read zero.
// - Bits 23 to 17 and 15 to 1 always read zero.
// - Stop or slow only when idle and, unless policy allows, host prepares stop.
`timescale 1ns/100ps
module scpm_top
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Socket side
  input  wire logic        card_access,
  input  wire logic        socket_idle,
  input  wire logic        host_clk_stop_prep,
  output logic             card_clk_stop,
  output logic             card_clk_slow,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]             sync1_ff;
  logic [2:0]             sync2_ff;
  logic [2:0]             nxt_sync1;
  logic [2:0]             nxt_sync2;
  logic                   acc_s;
  logic [31:0]            prdata_ff;
  logic [31:0]            nxt_prdata;
  logic                   pready_ff;
  logic                   nxt_pready;
  logic                   pslverr_ff;
  logic                   nxt_pslverr;
  logic                   seen_ff;
  logic                   nxt_seen;
  logic                   en_ff;
  logic                   nxt_en;
  logic                   sel_ff;
  logic                   nxt_sel;
  logic                   policy_ff;
  logic                   nxt_policy;
  logic [1:0]             ist_ff;
  logic [1:0]             nxt_ist;
  logic [1:0]             imask_ff;
  logic [1:0]             nxt_imask;
  logic                   mode_prev_ff;
  logic                   nxt_mode_prev;
  logic                   irq_ff;
  logic                   nxt_irq;
  logic                   rate_changed;
  logic                   cap;
  logic                   done;
  logic                   hit;
  logic [31:0]            rd_val;
  logic [1:0]             ev;
  scpm_pkg::scpm_ctrl_t   ctrl;
  scpm_pkg::scpm_sock_t   sock;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_comb
  begin
    nxt_sync1 = sync1_ff;
    nxt_sync2 = sync2_ff;
    if (ce)
    begin
      nxt_sync1 = {card_access, socket_idle, host_clk_stop_prep};
      nxt_sync2 = sync1_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign acc_s          = sync2_ff[2];
  assign sock.idle      = sync2_ff[1];
  assign sock.host_prep = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Clock policy
  assign ctrl.enable = en_ff;
  assign ctrl.select = sel_ff;
  assign ctrl.policy = policy_ff;

  scpm_clk_policy u_policy
  (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .ctrl         (ctrl),
    .sock         (sock),
    .clk_stop     (card_clk_stop),
    .clk_slow     (card_clk_slow),
    .rate_changed (rate_changed)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode and read mux
  assign cap  = psel & penable & ~pready_ff;
  assign done = psel & penable & pready_ff;

  always_comb
  begin
    rd_val = scpm_pkg::WORD_ZERO;
    hit    = 1'b1;
    unique case (paddr)
      scpm_pkg::PM_OFS:
      begin
        rd_val[scpm_pkg::ACC_BIT]  = seen_ff;
        rd_val[scpm_pkg::MODE_BIT] = rate_changed;
        rd_val[scpm_pkg::EN_BIT]   = en_ff;
        rd_val[scpm_pkg::SEL_BIT]  = sel_ff;
      end
      scpm_pkg::IRQ_STAT_OFS:
        rd_val[1:0] = ist_ff;
      scpm_pkg::IRQ_MASK_OFS:
        rd_val[1:0] = imask_ff;
      scpm_pkg::POLICY_OFS:
        rd_val[scpm_pkg::POLICY_BIT] = policy_ff;
      default:
        hit = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_prdata  = prdata_ff;
    nxt_pready  = pready_ff;
    nxt_pslverr = pslverr_ff;
    if (ce)
    begin
      nxt_pready  = cap;
      nxt_pslverr = cap & ~hit;
      if (cap)
        nxt_prdata = pwrite ? scpm_pkg::WORD_ZERO : rd_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff  <= scpm_pkg::WORD_ZERO;
      pready_ff  <= scpm_pkg::BIT_RST;
      pslverr_ff <= scpm_pkg::BIT_RST;
    end
    else
    begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // Control and status registers
  always_comb
  begin
    nxt_seen   = seen_ff;
    nxt_en     = en_ff;
    nxt_sel    = sel_ff;
    nxt_policy = policy_ff;
    nxt_imask  = imask_ff;
    if (ce)
    begin
      if (done && !pwrite && paddr == scpm_pkg::PM_OFS && prdata_ff[scpm_pkg::ACC_BIT])
        nxt_seen = 1'b0;
      if (acc_s)
        nxt_seen = 1'b1;
      if (done && pwrite)
      begin
        if (paddr == scpm_pkg::PM_OFS)
        begin
          if (pstrb[0])
            nxt_sel = pwdata[scpm_pkg::SEL_BIT];
          if (pstrb[2])
            nxt_en = pwdata[scpm_pkg::EN_BIT];
        end
        if (paddr == scpm_pkg::IRQ_MASK_OFS && pstrb[0])
          nxt_imask = pwdata[1:0];
        if (paddr == scpm_pkg::POLICY_OFS && pstrb[0])
          nxt_policy = pwdata[scpm_pkg::POLICY_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_ff   <= scpm_pkg::BIT_RST;
      en_ff     <= scpm_pkg::BIT_RST;
      sel_ff    <= scpm_pkg::BIT_RST;
      policy_ff <= scpm_pkg::BIT_RST;
      imask_ff  <= scpm_pkg::IRQ_RST;
    end
    else
    begin
      seen_ff   <= nxt_seen;
      en_ff     <= nxt_en;
      sel_ff    <= nxt_sel;
      policy_ff <= nxt_policy;
      imask_ff  <= nxt_imask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status
  assign ev[scpm_pkg::IRQ_ACC_BIT]  = acc_s;
  assign ev[scpm_pkg::IRQ_MODE_BIT] = rate_changed ^ mode_prev_ff;

  always_comb
  begin
    nxt_ist       = ist_ff;
    nxt_mode_prev = mode_prev_ff;
    nxt_irq       = irq_ff;
    if (ce)
    begin
      if (done && !pwrite && paddr == scpm_pkg::IRQ_STAT_OFS)
        nxt_ist = ist_ff & ~prdata_ff[1:0];
      nxt_ist       = nxt_ist | ev;
      nxt_mode_prev = rate_changed;
      nxt_irq       = |(nxt_ist & imask_ff);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_ff       <= scpm_pkg::IRQ_RST;
      mode_prev_ff <= scpm_pkg::BIT_RST;
      irq_ff       <= scpm_pkg::BIT_RST;
    end
    else
    begin
      ist_ff       <= nxt_ist;
      mode_prev_ff <= nxt_mode_prev;
      irq_ff       <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd_pm;
    ce && cap && !pwrite && paddr == scpm_pkg::PM_OFS;
  endsequence

  sequence s_rd_pm_done;
    s_rd_pm ##1 (ce && done);
  endsequence

  property p_acc_set;
    ce && acc_s |=> seen_ff;
  endproperty
  a_acc_set: assert property (p_acc_set) else $error("access flag not set");

  property p_rd_clear;
    s_rd_pm_done and (##1 prdata_ff[scpm_pkg::ACC_BIT] && !acc_s) |=> !seen_ff;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("access flag not cleared");

  property p_mode_rd;
    s_rd_pm |=> pready_ff && prdata_ff[scpm_pkg::MODE_BIT] == $past(rate_changed);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode bit wrong");

  property p_en_gate;
    ce && !en_ff |=> !card_clk_stop && !card_clk_slow;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("clock held while disabled");

  property p_slow_sel;
    ce && en_ff && sel_ff && sock.idle && (policy_ff || sock.host_prep) |=> card_clk_slow && !card_clk_stop;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("slow not chosen");

  property p_stop_sel;
    ce && en_ff && !sel_ff && sock.idle && (policy_ff || sock.host_prep) |=> card_clk_stop && !card_clk_slow;
  endproperty
  a_stop_sel: assert property (p_stop_sel) else $error("stop not chosen");

  property p_rsvd_hi;
    s_rd_pm |=> prdata_ff[31:26] == 6'h0;
  endproperty
  a_rsvd_hi: assert property (p_rsvd_hi) else $error("upper reserved bits set");

  property p_rsvd_mid;
    s_rd_pm |=> prdata_ff[23:17] == 7'h0 && prdata_ff[15:1] == 15'h0;
  endproperty
  a_rsvd_mid: assert property (p_rsvd_mid) else $error("reserved bits set");

  property p_idle_gate;
    ce && (!sock.idle || (!policy_ff && !sock.host_prep)) |=> !card_clk_stop && !card_clk_slow;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("clock held without permission");

endmodule : scpm_top

// file: sim/scpm_card_model.sv
// Purpose: Card side of the socket, driving the socket pins
// Assumes: Bench commands change just after a rising edge
// Notes:   Pins are registered, so they move one edge after a command
`timescale 1ns/100ps
module scpm_card_model
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Bench commands
  input  wire logic act_cmd,
  input  wire logic idle_cmd,
  input  wire logic prep_cmd,
  // Socket pins
  output logic      card_access,
  output logic      socket_idle,
  output logic      host_clk_stop_prep
);
  ////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_access        <= 1'b0;
      socket_idle        <= 1'b0;
      host_clk_stop_prep <= 1'b0;
    end
    else
    begin
      card_access        <= act_cmd;
      socket_idle        <= idle_cmd & ~act_cmd;
      host_clk_stop_prep <= prep_cmd;
    end
  end
endmodule : scpm_card_model

// file: sim/scpm_top_bench.sv
// Purpose: Self-checking bench for the socket clock power block
// Assumes: APB slave with one wait state
// Notes:   Random data from a small shift register seeded with 91
`timescale 1ns/100ps
module scpm_top_bench;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        ce       = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [3:0]  pstrb    = 4'h0;
  logic        act_cmd  = 1'b0;
  logic        idle_cmd = 1'b0;
  logic        prep_cmd = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        card_access;
  logic        socket_idle;
  logic        host_clk_stop_prep;
  logic        card_clk_stop;
  logic        card_clk_slow;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [15:0] lfsr_st  = 16'h005B;
  logic [1:0]  ex;
  logic        en_x;
  logic        sel_x;
  int          bad_count   = 0;
  int          check_count = 0;

  always #50 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  // Design and card
  scpm_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_access(card_access), .socket_idle(socket_idle),
    .host_clk_stop_prep(host_clk_stop_prep), .card_clk_stop(card_clk_stop),
    .card_clk_slow(card_clk_slow), .irq(irq));
  scpm_card_model card (.sys_clk(sys_clk), .rst_n(rst_n), .act_cmd(act_cmd), .idle_cmd(idle_cmd),
    .prep_cmd(prep_cmd), .card_access(card_access), .socket_idle(socket_idle),
    .host_clk_stop_prep(host_clk_stop_prep));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function logic [1:0] exp_clk(input logic en, input logic sel, input logic pol, input logic idl,
                               input logic prp);
    if (en && idl && (pol || prp))
      return sel ? 2'h2 : 2'h1;
    return 2'h0;
  endfunction : exp_clk

  function logic [31:0] exp_pm(input logic acc, input logic rate, input logic en, input logic sel);
    return {6'h00, acc, rate, 7'h00, en, 15'h0000, sel};
  endfunction : exp_pm

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Access phase holds until pready is seen high at a rising edge
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pulse_access;
    @(posedge sys_clk);
    act_cmd <= 1'b1;
    @(posedge sys_clk);
    act_cmd <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : pulse_access

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, scpm_pkg::PM_OFS + 8'(4 * i), 32'h0000_0000, 4'hF);
      chk(rd, scpm_pkg::WORD_ZERO);
    end
    apb(1'b1, scpm_pkg::PM_OFS, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
    chk(rd, exp_pm(1'b0, 1'b0, 1'b1, 1'b1));
    pulse_access();
    apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
    chk(rd, exp_pm(1'b1, 1'b0, 1'b1, 1'b1));
    apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
    chk(rd, exp_pm(1'b0, 1'b0, 1'b1, 1'b1));
    for (int i = 0; i < 32; i++)
    begin
      idle_cmd <= i[3];
      prep_cmd <= i[4];
      apb(1'b1, scpm_pkg::POLICY_OFS, {31'h0000_0000, i[2]}, 4'hF);
      apb(1'b1, scpm_pkg::PM_OFS, {15'h0000, i[0], 15'h0000, i[1]}, 4'hF);
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      ex = exp_clk(i[0], i[1], i[2], i[3], i[4]);
      chk({30'h0000_0000, card_clk_slow, card_clk_stop}, {30'h0000_0000, ex});
      apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
      chk(rd, exp_pm(1'b0, |ex, i[0], i[1]));
    end
    idle_cmd <= 1'b0;
    en_x  = 1'b1;
    sel_x = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      lfsr_st = lfsr_next(lfsr_st);
      apb(1'b1, scpm_pkg::PM_OFS, {lfsr_st, ~lfsr_st}, lfsr_st[3:0]);
      if (lfsr_st[2])
        en_x = lfsr_st[0];
      if (lfsr_st[0])
        sel_x = ~lfsr_st[0];
      repeat (6) @(posedge sys_clk);
      apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
      chk(rd, exp_pm(1'b0, 1'b0, en_x, sel_x));
    end
    apb(1'b0, scpm_pkg::IRQ_STAT_OFS, 32'h0000_0000, 4'hF);
    pulse_access();
    @(negedge sys_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, scpm_pkg::IRQ_MASK_OFS, 32'h0000_0001, 4'hF);
    repeat (2) @(negedge sys_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b0, scpm_pkg::IRQ_STAT_OFS, 32'h0000_0000, 4'hF);
    chk(rd, 32'h0000_0001);
    repeat (2) @(negedge sys_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000, 4'hF);
    chk({rd[30:0], er}, 32'h0000_0001);
    apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
    chk(rd, exp_pm(1'b1, 1'b0, en_x, sel_x));
    // Frozen clock enable drops a card access
    ce <= 1'b0;
    pulse_access();
    ce <= 1'b1;
    apb(1'b0, scpm_pkg::PM_OFS, 32'h0000_0000, 4'hF);
    chk(rd, exp_pm(1'b0, 1'b0, en_x, sel_x));
    end_sim();
  end

  initial
  begin
    repeat (10000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule : scpm_top_bench
